/* File: sim/rsr_psi5_receiver_asserts.sv */
// Port-level checks for the sensor receiver
`timescale 1ns/100ps
module rsr_psi5_receiver_asserts
  import rsr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_CH-1:0] short_gnd_in,
  input wire logic [NUM_CH-1:0] demod_in,
  input wire logic [NUM_CH-1:0] sensor_supply_output,
  input wire logic [NUM_CH-1:0] channel_on,
  input wire logic [NUM_CH-1:0] discrete_decoded_outputs,
  input wire logic sensor_fault_summary
);
  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd_gsw = psel && !penable && !pwrite && paddr == OFF_GSW;
  wire logic [3:0] wr_on = pwdata[3:0];

  a_read_answer:
    assert property (psel && !penable |=> pready ##1 !pready) else $error("setup not answered in one cycle");
  a_unmapped_err:
    assert property (psel && !penable && paddr == 8'h4c |=> pready && pslverr) else $error("unmapped slot accepted");
  a_ctrl_on:
    assert property (psel && penable && pwrite && paddr == OFF_CTRL |=> channel_on == $past(wr_on))
      else $error("channel state not taken from control write");
  a_sync_width:
    assert property ($rose(sensor_supply_output[0]) |-> ##19 sensor_supply_output[0] ##1 !sensor_supply_output[0])
      else $error("sync pulse width wrong");
  a_sync_single:
    assert property ($onehot0(sensor_supply_output)) else $error("sync pulses overlap");
  a_sync_on_only:
    assert property ((sensor_supply_output & ~channel_on) == 4'h0) else $error("sync pulse on switched off channel");
  a_fault_set:
    assert property (short_gnd_in[0] && channel_on[0] |-> ##[1:3] sensor_fault_summary) else $error("summary not set");
  // Only a status read may drop the summary bit, never a quiet interval
  a_fault_hold:
    assert property (sensor_fault_summary && !rd_gsw |=> sensor_fault_summary) else $error("summary dropped unread");
  a_off_quiet:
    assert property (!channel_on[0] [*4] |-> !discrete_decoded_outputs[0]) else $error("decoded output while off");
  // Filter output is registered twice, so a change mirrors the line level two samples back
  a_disc_follow:
    assert property (channel_on[0] && $changed(discrete_decoded_outputs[0])
      |-> discrete_decoded_outputs[0] == $past(demod_in[0], 2))
      else $error("decoded output not following filtered level");
endmodule // rsr_psi5_receiver_asserts

bind rsr_psi5_receiver rsr_psi5_receiver_asserts u_asserts (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .short_gnd_in, .demod_in, .sensor_supply_output, .channel_on, .discrete_decoded_outputs,
  .sensor_fault_summary);

/* File: sim/rsr_sensor_model.sv */
// Behavioural loop sensor producing demodulated current levels
`timescale 1ns/100ps
module rsr_sensor_model
(
  input wire logic pclk,
  output logic [3:0] demod
);
  // ==========================================================================
  // Frame sender
  initial demod = 4'h0;

  // Two zero start bits, payload LSB first, even parity, two idle bit times
  // Level bit 0 low then high, bit 1 high then low: mid-bit edge carries the value
  task automatic frame(input int ch, input int h, input int n, input logic [9:0] d, input logic bad);
    logic v;
    for (int i = 0; i < n + 3; i++)
    begin
      v = (i < 2) ? 1'b0 : (i < n + 2) ? d[i-2] : (^d) ^ bad;
      demod[ch] <= v;
      repeat (h) @(posedge pclk);
      demod[ch] <= ~v;
      repeat (h) @(posedge pclk);
    end
    demod[ch] <= 1'b0;
    repeat (4 * h) @(posedge pclk);
  endtask
endmodule // rsr_sensor_model

/* File: sim/tb_top.sv */
// Self-checking bench for the four-channel sensor receiver
`timescale 1ns/100ps
module tb_top
  import rsr_pkg::*;
;
  localparam logic [32:0] ALL = 33'h1_ffff_ffff;
  localparam logic [32:0] DMSK = 33'h1_0008_63ff;
  // 189k/10b, 189k/8b, filter 15, 125k late end, 125k unchecked, bad parity
  localparam logic [71:0] CFGS = 72'h003_00a_002_f03_001_003;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sync_in, fault_sum;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] demod, curr_lim, short_gnd, over_temp, supply, on, disc;
  logic [32:0] exp_q[$], msk_q[$];
  int n_fail, n_tests, seed;

  rsr_psi5_receiver #(.BLANK_SHORT_CYC(50), .BLANK_LONG_CYC(100)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .demod_in(demod), .sync_trigger_input(sync_in),
    .curr_limit_in(curr_lim), .short_gnd_in(short_gnd), .over_temp_in(over_temp), .sensor_supply_output(supply),
    .channel_on(on), .discrete_decoded_outputs(disc), .sensor_fault_summary(fault_sum));
  rsr_sensor_model u_sensor (.pclk, .demod);

  // ==========================================================================
  // Clock, watchdog, closing
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial
  begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    end_sim();
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // Bus master and result checking
  task automatic chk(input logic [32:0] e, input logic [32:0] m, input logic [32:0] g);
    n_tests++;
    if ((g & m) !== (e & m))
    begin
      n_fail++;
      $display("wrong value read_word expected %h seen %h", e & m, g & m);
    end
  endtask

  // Expectation is queued when the read is issued, checked when pready comes
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e,
      input logic [32:0] m);
    if (!w)
    begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait-state count is assumed; only the watchdog ends a hung access
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      chk(exp_q.pop_front(), msk_q.pop_front(), {pslverr, prdata});

  // ==========================================================================
  // Scenarios
  initial
  begin
    logic [11:0] c;
    logic [9:0] d;
    logic [32:0] e;
    {presetn, psel, penable, pwrite, sync_in} = 5'h00;
    {paddr, pwdata} = 40'h00_0000_0000;
    {curr_lim, short_gnd, over_temp} = 12'h000;
    seed = 32'h0000_711c;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, OFF_CFG_BASE, 0, {1'b0, CFG_RESET}, ALL);
    apb(0, OFF_CTRL, 0, 33'h0, ALL);
    apb(0, OFF_DATA_BASE + 8'h0c, 0, 33'h1_0000_0000, ALL);
    apb(1, OFF_CTRL, 32'h0000_005f, 0, 0);
    apb(0, OFF_GSW, 0, 33'h0_0000_000f, ALL);
    for (int k = 0; k < 6; k++)
    begin
      c = CFGS[k*12 +: 12];
      d = 10'($random(seed)) & (c[1] ? 10'h3ff : 10'h0ff);
      apb(1, OFF_CFG_BASE, {20'h0_0000, c}, 0, 0);
      sync_in <= 1'b1;
      u_sensor.frame(0, c[0] ? 26 : 40, c[1] ? 10 : 8, d, k == 5);
      sync_in <= 1'b0;
      // Register must still be empty inside the write delay
      if (k == 0)
        apb(0, OFF_DATA_BASE, 0, {1'b0, 12'h0, NO_DATA_WORD}, ALL);
      repeat (150) @(posedge pclk);
      e = (k == 3) ? 33'h0_0008_0002 : (k == 5) ? 33'h0_0008_0001 : {23'h00_2000 >> 10, d};
      apb(0, OFF_DATA_BASE, 0, e, (k == 3 || k == 5) ? ALL : DMSK);
      apb(0, OFF_DATA_BASE, 0, {1'b0, 12'h0, NO_DATA_WORD}, ALL);
    end
    // Clear the summary left by the frame faults so the short alone must set it again
    apb(0, OFF_GSW, 0, 33'h0_0000_010f, ALL);
    short_gnd <= 4'h1;
    repeat (5) @(posedge pclk);
    short_gnd <= 4'h0;
    repeat (5) @(posedge pclk);
    for (int s = 0; s < 3; s++)
      apb(0, OFF_DATA_BASE + 8'(4 * s), 0, 33'h0_0008_0010, ALL);
    apb(0, OFF_DATA_BASE + 8'h10, 0, {1'b0, 12'h0, NO_DATA_WORD}, ALL);
    apb(0, OFF_GSW, 0, 33'h0_0000_010f, ALL);
    apb(0, OFF_GSW, 0, 33'h0_0000_000f, ALL);
    end_sim();
  end
endmodule // tb_top

/* File: verilog/rsr_pkg.sv */
// Constants, register map and state types of the four-channel sensor receiver
package rsr_pkg;

  // ==========================================================================
  // Structure
  localparam int NUM_CH = 4;
  localparam int NUM_SLOT = 3;
  localparam int CLK_PERIOD_NS = 100;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_GSW = 8'h04;
  localparam logic [7:0] OFF_CFG_BASE = 8'h10;
  localparam logic [7:0] OFF_DATA_BASE = 8'h40;

  // Control register: channel enable and sync pulse enable
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_SYNC_LSB = 4;
  localparam logic [31:0] CTRL_MASK = 32'h0000_00ff;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Global status word
  localparam int GSW_ON_LSB = 0;
  localparam int GSW_FAULT_BIT = 8;

  // Per channel configuration register
  localparam int CFG_RATE_BIT = 0;
  localparam int CFG_LEN10_BIT = 1;
  localparam int CFG_MAN1_BIT = 2;
  localparam int CFG_SLOTDIS_BIT = 3;
  localparam int CFG_BLANK_BIT = 4;
  localparam int CFG_FILT_LSB = 8;
  localparam logic [31:0] CFG_MASK = 32'h0000_0f1f;
  localparam logic [31:0] CFG_RESET = 32'h0000_0002;

  // Data register layout
  localparam int DATA_W = 20;
  localparam int CRC_LSB = 10;
  localparam int LOGICAL_CHANNEL_ID_LSB = 13;
  localparam int FLT_MSB = 19;
  localparam int F_INVALID = 0;
  localparam int F_SLOT = 1;
  localparam int F_NODATA = 2;
  localparam int F_CURR = 3;
  localparam logic [DATA_W-1:0] FLT_MSB_MASK = 20'h8_0000;
  localparam logic [DATA_W-1:0] NO_DATA_WORD = 20'h8_0004;
  localparam logic [DATA_W-1:0] KEEP_ON_OFF_MASK = 20'h0_000b;

  // ==========================================================================
  // Frame format
  localparam logic [3:0] START_BITS = 4'h2;
  localparam logic [3:0] LEN8 = 4'h8;
  localparam logic [3:0] LEN10 = 4'ha;
  localparam logic [3:0] PARITY_BITS = 4'h1;
  localparam logic [2:0] CRC_SEED = 3'h7;

  // ==========================================================================
  // Timing
  localparam int BIT_NS_125 = 8000;
  localparam int BIT_NS_189 = 5291;
  localparam int BIT_CYC_125 = BIT_NS_125 / CLK_PERIOD_NS;
  localparam int BIT_CYC_189 = BIT_NS_189 / CLK_PERIOD_NS;
  localparam logic [7:0] WIN_Q_125 = 8'(BIT_CYC_125 / 4);
  localparam logic [7:0] WIN_LO_125 = 8'(BIT_CYC_125 * 3 / 4);
  localparam logic [7:0] WIN_HI_125 = 8'(BIT_CYC_125 * 5 / 4);
  localparam logic [7:0] WIN_Q_189 = 8'(BIT_CYC_189 / 4);
  localparam logic [7:0] WIN_LO_189 = 8'(BIT_CYC_189 * 3 / 4);
  localparam logic [7:0] WIN_HI_189 = 8'(BIT_CYC_189 * 5 / 4);

  localparam int WRITE_DELAY_NS = 10000;
  localparam logic [7:0] WRITE_DELAY_CYC = 8'((WRITE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int SYNC_PULSE_NS = 2000;
  localparam logic [7:0] SYNC_PULSE_CYC = 8'((SYNC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Slot windows, measured from the sync sequencer's turn for the channel, whether or not its pulse is output
  localparam int SLOT1_LO_NS = 60000;
  localparam int SLOT1_HI_NS = 100000;
  localparam int SLOT2_LO_NS = 160000;
  localparam int SLOT2_HI_NS = 200000;
  localparam int SLOT3_LO_NS = 260000;
  localparam int SLOT3_HI_NS = 300000;
  localparam logic [11:0] SLOT1_LO = 12'((SLOT1_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] SLOT1_HI = 12'(SLOT1_HI_NS / CLK_PERIOD_NS);
  localparam logic [11:0] SLOT2_LO = 12'((SLOT2_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] SLOT2_HI = 12'(SLOT2_HI_NS / CLK_PERIOD_NS);
  localparam logic [11:0] SLOT3_LO = 12'((SLOT3_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] SLOT3_HI = 12'(SLOT3_HI_NS / CLK_PERIOD_NS);
  localparam logic [11:0] SLOT_TIMER_MAX = 12'hfff;

  localparam int BLANK_W = 17;
  localparam int BLANK_SHORT_US = 5000;
  localparam int BLANK_LONG_US = 10000;
  localparam int BLANK_SHORT_DEF = BLANK_SHORT_US * 1000 / CLK_PERIOD_NS;
  localparam int BLANK_LONG_DEF = BLANK_LONG_US * 1000 / CLK_PERIOD_NS;

  // ==========================================================================
  // State types
  typedef enum logic [2:0] {DEC_IDLE = 3'b001, DEC_BITS = 3'b010, DEC_SKIP = 3'b100} rsr_dec_state_t;
  typedef enum logic [1:0] {SY_IDLE = 2'b01, SY_PULSE = 2'b10} rsr_sync_state_t;

endpackage

/* File: verilog/rsr_psi5_receiver.sv */
// Four-channel current-loop sensor receiver with APB register access
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps

// Operation
// - Four independent channels, up to three sensors each; faults stay per channel.
// - Host switches each channel on/off and reads back every channel's on state.
// - Bit value from mid-bit edge; Manchester-2 normally, Manchester-1 when selected.
// - Per-channel choice of 125 kbps or 189 kbps bit rate.
// - Per-channel choice of 8 or 10 data bits plus one parity bit.
// - Per-channel deglitch filter, sixteen selectable delay steps.
// - Three data registers per channel, one per timeslot; messages go to their slot.
// - Data register loads whole, a fixed delay after the message ends.
// - Reading a data register clears it; reads before new data return an error word.
// - On sync input rising edge, pulse channels zero to three one after another.
// - Sync pulses only on channels with sync enabled in the control register.
// - Message ending outside its slot window records a slot fault in that slot.
// - Second message ending before its window flags slot one, first data lost.
// - Two messages ending in one slot: the later one is kept regardless.
// - Per-channel bit disables slot window checking and its faults.
// - Current-limit fault blanked 5 ms or 10 ms after each channel activation.
// - Bit errors discard the message and reset bit timing to nominal window.
// - Invalid flag is OR of start, length, parity and bit-time errors.
// - Channel faults go to all three slot registers, overriding valid data.
// - Fault word has MSB set with fault flags below; otherwise data, check bits and slot number.
// - Any fault sets global summary; clears on read, short/overtemp also on disable.
// - Three-bit check with polynomial 1+x+x^3, seeded all ones per frame.
// - Error unless exactly nine (8-bit) or eleven (10-bit) mid-bit transitions follow two start bits.
// - Eight-bit payload stored right-justified in the ten-bit data field.
module rsr_psi5_receiver
  import rsr_pkg::*;
#(
  parameter int BLANK_SHORT_CYC = BLANK_SHORT_DEF,
  parameter int BLANK_LONG_CYC = BLANK_LONG_DEF
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_CH-1:0] demod_in,
  input wire logic sync_trigger_input,
  input wire logic [NUM_CH-1:0] curr_limit_in,
  input wire logic [NUM_CH-1:0] short_gnd_in,
  input wire logic [NUM_CH-1:0] over_temp_in,
  output logic [NUM_CH-1:0] sensor_supply_output,
  output logic [NUM_CH-1:0] channel_on,
  output logic [NUM_CH-1:0] discrete_decoded_outputs,
  output logic sensor_fault_summary
);

  // ==========================================================================
  // APB decode
  logic [31:0] ctrl_reg;
  logic [31:0] cfg_arr [NUM_CH];
  logic [DATA_W-1:0] data_word [NUM_CH][NUM_SLOT];
  logic data_full [NUM_CH][NUM_SLOT];
  logic [NUM_CH-1:0] flt_evt;
  logic [NUM_CH-1:0] filt_vec;
  logic [NUM_CH-1:0] sync_vec;

  wire setup = psel && !penable;
  wire wr_take = psel && penable && pready && pwrite;
  // Read side effects happen when the data is captured, so nothing lands unseen in between
  wire rd_take = setup && !pwrite;
  wire is_ctrl = paddr == OFF_CTRL;
  wire is_gsw = paddr == OFF_GSW;
  wire is_cfg = paddr[7:4] == OFF_CFG_BASE[7:4] && paddr[1:0] == 2'b00;
  wire is_data = paddr[7:6] == OFF_DATA_BASE[7:6] && paddr[3:2] != 2'b11 && paddr[1:0] == 2'b00;
  wire addr_hit = is_ctrl || is_gsw || is_cfg || is_data;
  wire [1:0] cfg_ch = paddr[3:2];
  wire [1:0] d_ch = paddr[5:4];
  wire [1:0] d_slot = paddr[3:2];
  wire [31:0] gsw_word = {23'h00_0000, sensor_fault_summary, 4'h0, ctrl_reg[CTRL_EN_LSB +: NUM_CH]};
  wire [31:0] data_rd = data_full[d_ch][d_slot] ? {12'h000, data_word[d_ch][d_slot]}
                                                : {12'h000, NO_DATA_WORD};
  wire [31:0] rd_data = is_ctrl ? ctrl_reg :
                        is_gsw ? gsw_word :
                        is_cfg ? cfg_arr[cfg_ch] :
                        is_data ? data_rd : 32'h0000_0000;

  assign channel_on = ctrl_reg[CTRL_EN_LSB +: NUM_CH];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !addr_hit;
      if (rd_take)
        prdata <= rd_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= CTRL_RESET;
    else if (wr_take && is_ctrl)
      ctrl_reg <= pwdata & CTRL_MASK;
  end

  // ==========================================================================
  // Global status and registered pin outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sensor_fault_summary <= 1'b0;
      discrete_decoded_outputs <= '0;
      sensor_supply_output <= '0;
    end
    else
    begin
      // A new fault in the reading cycle wins over the clear
      if (|flt_evt)
        sensor_fault_summary <= 1'b1;
      else if (rd_take && is_gsw)
        sensor_fault_summary <= 1'b0;
      discrete_decoded_outputs <= filt_vec & channel_on;
      sensor_supply_output <= sync_vec;
    end
  end

  // ==========================================================================
  // Sync pulse sequencer
  rsr_sync_state_t sync_state;
  logic [1:0] sync_ch;
  logic [7:0] sync_cnt;
  logic sync_trig_d;

  wire sync_rise = sync_trigger_input && !sync_trig_d;
  wire sync_last = sync_cnt == SYNC_PULSE_CYC - 8'h01;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_state <= SY_IDLE;
      sync_ch <= 2'b00;
      sync_cnt <= 8'h00;
      sync_trig_d <= 1'b0;
    end
    else
    begin
      sync_trig_d <= sync_trigger_input;
      case (sync_state)
        SY_IDLE:
        begin
          sync_cnt <= 8'h00;
          sync_ch <= 2'b00;
          if (sync_rise)
            sync_state <= SY_PULSE;
        end
        SY_PULSE:
        begin
          // One channel at a time limits the inrush on the supply
          sync_cnt <= sync_last ? 8'h00 : sync_cnt + 8'h01;
          if (sync_last)
          begin
            if (sync_ch == 2'(NUM_CH - 1))
              sync_state <= SY_IDLE;
            else
              sync_ch <= sync_ch + 2'b01;
          end
        end
        default: sync_state <= SY_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Channel logic, fully independent per channel
  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_ch
    logic [31:0] cfg;
    logic [3:0] filt_cnt;
    logic filt;
    logic filt_d;
    rsr_dec_state_t dec_state;
    logic [7:0] btimer;
    logic [3:0] bit_cnt;
    logic [9:0] shreg;
    logic [2:0] crc;
    logic par;
    logic start_err;
    logic fin;
    logic [3:0] fin_flags;
    logic [9:0] fin_data;
    logic [2:0] fin_crc;
    logic [11:0] slot_timer;
    logic [DATA_W-1:0] pend_word;
    logic [1:0] pend_slot;
    logic pend_valid;
    logic [7:0] wd_cnt;
    logic [BLANK_W-1:0] blank_cnt;
    logic on_d;

    wire on = ctrl_reg[CTRL_EN_LSB + ch];
    wire sync_en = ctrl_reg[CTRL_SYNC_LSB + ch];
    wire rate189 = cfg[CFG_RATE_BIT];
    wire len10 = cfg[CFG_LEN10_BIT];
    wire man1 = cfg[CFG_MAN1_BIT];
    wire slot_dis = cfg[CFG_SLOTDIS_BIT];
    wire [3:0] filt_sel = cfg[CFG_FILT_LSB +: 4];
    wire [7:0] win_q = rate189 ? WIN_Q_189 : WIN_Q_125;
    wire [7:0] win_lo = rate189 ? WIN_LO_189 : WIN_LO_125;
    wire [7:0] win_hi = rate189 ? WIN_HI_189 : WIN_HI_125;
    wire [3:0] data_len = len10 ? LEN10 : LEN8;
    wire [3:0] exp_bits = START_BITS + data_len + PARITY_BITS;
    wire [3:0] data_end = START_BITS + data_len;
    wire raw = demod_in[ch] && on;
    wire edge_det = filt ^ filt_d;
    // Manchester-2 reads a rising mid-bit edge as zero, Manchester-1 as one
    wire bit_val = man1 ? filt : !filt;
    wire mid_ok = btimer >= win_lo && btimer <= win_hi;
    wire early = btimer < win_q;
    wire timeout = btimer > win_hi;
    wire crc_fb = crc[2] ^ bit_val;
    wire blank_done = blank_cnt == '0;
    wire [2:0] chf = {over_temp_in[ch], short_gnd_in[ch], curr_limit_in[ch] && blank_done} & {3{on}};
    wire [DATA_W-1:0] chf_word = FLT_MSB_MASK | (DATA_W'(chf) << F_CURR);
    wire [1:0] slot_sel = slot_timer < SLOT2_LO ? 2'd0 : slot_timer < SLOT3_LO ? 2'd1 : 2'd2;
    wire in_win = slot_sel == 2'd0 ? slot_timer >= SLOT1_LO && slot_timer <= SLOT1_HI :
                  slot_sel == 2'd1 ? slot_timer <= SLOT2_HI : slot_timer <= SLOT3_HI;
    wire slot_fault = !slot_dis && !in_win;
    wire commit = pend_valid && wd_cnt == 8'h00;

    assign cfg_arr[ch] = cfg;
    assign filt_vec[ch] = filt;
    assign sync_vec[ch] = sync_state == SY_PULSE && sync_ch == 2'(ch) && on && sync_en;
    assign flt_evt[ch] = (commit && pend_word[FLT_MSB]) || (chf != 3'b000);

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        cfg <= CFG_RESET;
      else if (wr_take && is_cfg && cfg_ch == 2'(ch))
        cfg <= pwdata & CFG_MASK;
    end

    // Deglitch: a level change must hold for filt_sel + 1 clock ticks
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        filt <= 1'b0;
        filt_d <= 1'b0;
        filt_cnt <= 4'h0;
      end
      else
      begin
        filt_d <= filt;
        if (raw == filt)
          filt_cnt <= 4'h0;
        else if (filt_cnt >= filt_sel)
        begin
          filt <= raw;
          filt_cnt <= 4'h0;
        end
        else
          filt_cnt <= filt_cnt + 4'h1;
      end
    end

    // Manchester decoder; the first accepted edge is the first start bit's mid-bit
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        dec_state <= DEC_IDLE;
        btimer <= 8'h00;
        bit_cnt <= 4'h0;
        shreg <= 10'h000;
        crc <= CRC_SEED;
        par <= 1'b0;
        start_err <= 1'b0;
        fin <= 1'b0;
        fin_flags <= 4'h0;
        fin_data <= 10'h000;
        fin_crc <= 3'h0;
      end
      else
      begin
        fin <= 1'b0;
        case (dec_state)
          DEC_IDLE:
          begin
            btimer <= 8'h00;
            if (edge_det)
            begin
              dec_state <= DEC_BITS;
              bit_cnt <= 4'h1;
              start_err <= bit_val;
              par <= 1'b0;
              crc <= CRC_SEED;
              shreg <= 10'h000;
            end
          end
          DEC_BITS:
          begin
            btimer <= btimer + 8'h01;
            if (!on)
              dec_state <= DEC_IDLE;
            else if (edge_det && mid_ok)
            begin
              btimer <= 8'h00;
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt >= exp_bits)
              begin
                fin <= 1'b1;
                fin_flags <= 4'b0010;
                dec_state <= DEC_SKIP;
              end
              else if (bit_cnt < START_BITS)
                start_err <= start_err | bit_val;
              else if (bit_cnt < data_end)
              begin
                shreg <= {bit_val, shreg[9:1]};
                crc <= {crc[1], crc[0] ^ crc_fb, crc_fb};
                par <= par ^ bit_val;
              end
              else
                par <= par ^ bit_val;
            end
            else if (edge_det && early)
            begin
              fin <= 1'b1;
              fin_flags <= 4'b1000;
              dec_state <= DEC_SKIP;
            end
            else if (timeout)
            begin
              // A quiet stretch past win_hi, five quarters of a bit time, closes the frame
              fin <= 1'b1;
              fin_flags <= {1'b0, par, bit_cnt != exp_bits, start_err};
              fin_data <= len10 ? shreg : {2'b00, shreg[9:2]};
              fin_crc <= crc;
              dec_state <= DEC_IDLE;
            end
          end
          DEC_SKIP:
          begin
            // Discarded frame: wait for quiet line, timing restarts from the nominal window
            btimer <= edge_det ? 8'h00 : btimer + 8'h01;
            if (timeout || !on)
              dec_state <= DEC_IDLE;
          end
          default: dec_state <= DEC_IDLE;
        endcase
      end
    end

    // Slot timer, restarted when the sync sequencer reaches this channel, whether or not its pulse is output
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        slot_timer <= SLOT_TIMER_MAX;
      else if (sync_state == SY_PULSE && sync_ch == 2'(ch) && sync_cnt == 8'h00)
        slot_timer <= 12'h000;
      else if (slot_timer != SLOT_TIMER_MAX)
        slot_timer <= slot_timer + 12'h001;
    end

    // Result held for the write delay; a newer frame replaces it
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        pend_valid <= 1'b0;
        pend_word <= '0;
        pend_slot <= 2'd0;
        wd_cnt <= 8'h00;
      end
      else if (fin)
      begin
        pend_valid <= 1'b1;
        pend_slot <= slot_sel;
        wd_cnt <= WRITE_DELAY_CYC;
        if (fin_flags != 4'h0 || slot_fault)
          pend_word <= FLT_MSB_MASK | (DATA_W'(fin_flags != 4'h0) << F_INVALID)
                       | (DATA_W'(slot_fault) << F_SLOT);
        else
          pend_word <= {5'h00, slot_sel + 2'd1, fin_crc, fin_data};
      end
      else if (pend_valid)
      begin
        if (commit)
          pend_valid <= 1'b0;
        else
          wd_cnt <= wd_cnt - 8'h01;
      end
    end

    // Current-limit blanking after each switch-on
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        on_d <= 1'b0;
        blank_cnt <= '0;
      end
      else
      begin
        on_d <= on;
        if (on && !on_d)
          blank_cnt <= cfg[CFG_BLANK_BIT] ? BLANK_W'(BLANK_LONG_CYC) : BLANK_W'(BLANK_SHORT_CYC);
        else if (!blank_done)
          blank_cnt <= blank_cnt - BLANK_W'(1);
      end
    end

    for (genvar s = 0; s < NUM_SLOT; s++)
    begin : g_slot
      wire rd_clr = rd_take && is_data && d_ch == 2'(ch) && d_slot == 2'(s);
      wire drop_off = !on && data_word[ch][s][FLT_MSB] && (data_word[ch][s] & KEEP_ON_OFF_MASK) == '0;

      // Later assignments win: new data or faults beat the read clear
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          data_word[ch][s] <= '0;
          data_full[ch][s] <= 1'b0;
        end
        else
        begin
          if (rd_clr || drop_off)
            data_full[ch][s] <= 1'b0;
          if (commit && pend_slot == 2'(s))
          begin
            data_word[ch][s] <= pend_word;
            data_full[ch][s] <= 1'b1;
          end
          if (chf != 3'b000)
          begin
            data_word[ch][s] <= chf_word;
            data_full[ch][s] <= 1'b1;
          end
        end
      end
    end
  end

endmodule // rsr_psi5_receiver
